// ### src/tcc_defines.svh
// Offsets, field positions, reset values and prescaler masks of the timer.
// Assumes byte addresses of an 8-bit window on a 32-bit AXI4-Lite bus.
`ifndef TCC_DEFINES_SVH
`define TCC_DEFINES_SVH

// ==========================================================================
// Register byte offsets
`define TCC_OFS_CTRL_A 8'h00
`define TCC_OFS_CTRL_B 8'h04
`define TCC_OFS_COUNT 8'h08
`define TCC_OFS_CMP_A 8'h0C
`define TCC_OFS_CMP_B 8'h10
`define TCC_OFS_FLAG 8'h14
`define TCC_OFS_MASK 8'h18

// ==========================================================================
// Field positions
`define TCC_CA_WGM_LO 0
`define TCC_CA_COMB_LO 4
`define TCC_CA_COMA_LO 6
`define TCC_CB_CS_LO 0
`define TCC_CB_WGM2 3
`define TCC_CB_FORCE_B 6
`define TCC_CB_FORCE_A 7
`define TCC_FLG_OVF 0
`define TCC_FLG_CMP_A 1
`define TCC_FLG_CMP_B 2

// ==========================================================================
// Values
`define TCC_RST_BYTE 8'h00
`define TCC_BOTTOM 8'h00
`define TCC_MAX 8'hFF
`define TCC_CS_STOP 3'h0
`define TCC_CS_DIV1 3'h1
`define TCC_CS_DIV8 3'h2
`define TCC_CS_DIV64 3'h3
`define TCC_CS_DIV256 3'h4
`define TCC_CS_DIV1024 3'h5
`define TCC_CS_EXT_FALL 3'h6
`define TCC_CS_EXT_RISE 3'h7
`define TCC_MASK_DIV8 10'h007
`define TCC_MASK_DIV64 10'h03F
`define TCC_MASK_DIV256 10'h0FF
`define TCC_MASK_DIV1024 10'h3FF
`define TCC_RESP_OKAY 2'h0
`define TCC_RESP_SLVERR 2'h2

`endif

// ### src/tcc_pkg.sv
// Types shared by the timer core and its compare units.
// Assumes tcc_defines.svh carries every numeric constant.
package tcc_pkg;

  // ========================================================================
  // Counting sequence class
  typedef enum logic [1:0] {
    TCC_KIND_NORMAL = 2'b00,
    TCC_KIND_CTC = 2'b01,
    TCC_KIND_FAST = 2'b10,
    TCC_KIND_PHASE = 2'b11
  } tcc_kind_e;

  typedef struct packed {
    tcc_kind_e kind;
    logic [1:0] action;
  } tcc_wave_cfg_s;

  typedef struct packed {
    logic [7:0] count;
    logic dir_up;
    logic at_top;
    logic block;
  } tcc_cnt_stat_s;

endpackage

// ### src/tcc_tick_sel.sv
// Timer tick source: prescaler taps or edges of the external count pin.
// Assumes ext_pin is asynchronous to clk.
`include "tcc_defines.svh"
module tcc_tick_sel (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [2:0] clock_select,
  input wire logic ext_pin,
  output logic tick_q
);

  logic sync1_q;
  logic sync2_q;
  logic prev_q;
  logic [9:0] pre_q;

  // ========================================================================
  // Pin synchroniser and prescaler
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      prev_q <= 1'b0;
    end else begin
      sync1_q <= ext_pin;
      sync2_q <= sync1_q;
      prev_q <= sync2_q;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pre_q <= 10'h000;
    end else begin
      pre_q <= pre_q + 10'h001;
    end
  end

  // ========================================================================
  // Tick select
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tick_q <= 1'b0;
    end else begin
      case (clock_select)
        `TCC_CS_STOP: tick_q <= 1'b0;
        `TCC_CS_DIV1: tick_q <= 1'b1;
        `TCC_CS_DIV8: tick_q <= &(pre_q | ~`TCC_MASK_DIV8);
        `TCC_CS_DIV64: tick_q <= &(pre_q | ~`TCC_MASK_DIV64);
        `TCC_CS_DIV256: tick_q <= &(pre_q | ~`TCC_MASK_DIV256);
        `TCC_CS_DIV1024: tick_q <= &(pre_q | ~`TCC_MASK_DIV1024);
        `TCC_CS_EXT_FALL: tick_q <= prev_q & ~sync2_q;
        `TCC_CS_EXT_RISE: tick_q <= sync2_q & ~prev_q;
        default: tick_q <= 1'b0;
      endcase
    end
  end

endmodule // tcc_tick_sel

// ### src/tcc_cmp_unit.sv
// One output compare unit: buffered compare value, match and waveform.
// Assumes tick is a one-cycle pulse and stat comes from the same clock.
`include "tcc_defines.svh"
module tcc_cmp_unit (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic wr_en,
  input wire logic [7:0] wr_data,
  input wire logic tick,
  input tcc_pkg::tcc_cnt_stat_s stat,
  input tcc_pkg::tcc_wave_cfg_s cfg,
  input wire logic force_strobe,
  output logic [7:0] active_q,
  output logic [7:0] buffer_q,
  output logic match_set,
  output logic oc_q
);

  logic pwm;
  logic match_evt;

  assign pwm = (cfg.kind == tcc_pkg::TCC_KIND_FAST) ||
               (cfg.kind == tcc_pkg::TCC_KIND_PHASE);
  // Equality is taken on a tick, so the flag rises one timer tick later
  assign match_evt = tick && (stat.count == active_q) && !stat.block;
  assign match_set = match_evt;

  // ========================================================================
  // Compare value and its buffer
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      buffer_q <= `TCC_RST_BYTE;
    end else if (wr_en) begin
      buffer_q <= wr_data;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      active_q <= `TCC_RST_BYTE;
    end else if (wr_en && !pwm) begin
      active_q <= wr_data;
    end else if (pwm && tick && stat.at_top) begin
      active_q <= buffer_q;
    end
  end

  // ========================================================================
  // Waveform output
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      oc_q <= 1'b0;
    end else begin
      case (cfg.kind)
        tcc_pkg::TCC_KIND_FAST: begin
          if (match_evt && cfg.action[1]) begin
            oc_q <= cfg.action[0];
          end
          // Wrap to bottom wins, so a compare value at top holds the level
          if (tick && stat.at_top && cfg.action[1]) begin
            oc_q <= ~cfg.action[0];
          end
        end
        tcc_pkg::TCC_KIND_PHASE: begin
          if (match_evt && cfg.action[1]) begin
            oc_q <= stat.dir_up ~^ cfg.action[0];
          end
        end
        default: begin
          if (match_evt || force_strobe) begin
            case (cfg.action)
              2'h1: oc_q <= ~oc_q;
              2'h2: oc_q <= 1'b0;
              2'h3: oc_q <= 1'b1;
              default: oc_q <= oc_q;
            endcase
          end
        end
      endcase
    end
  end

endmodule // tcc_cmp_unit

// ### src/tcc_timer.sv
// 8-bit timer/counter with two compare units behind an AXI4-Lite slave.
// Assumes one clock; external_count_pin is asynchronous; irq_ack pulses
// come from the interrupt controller on clk.
//
// Function
// - Two independent compare units, each own output
// - Counter and compare values are 8 bits
// - One flag register, separate per-bit mask register
// - Tick from prescaler or external pin edge
// - Clock select zero stops the counter
// - Tick clears, increments or decrements per mode
// - Count readable and writable at any time
// - Software count write beats counter update
// - Mode field: two bits control A, one B
// - Bottom is 0x00, maximum is 0xFF
// - Top is 0xFF or compare value A
// - Overflow flag set per mode, can interrupt
// - Comparators check count against both compare values
// - Match sets flag on following timer tick
// - Enabled flag requests interrupt, cleared when serviced
// - Writing one clears a flag, zero keeps
// - Output derived from match, mode and action
// - Top and bottom handle extreme-value cases
// - Compare values buffered only in PWM modes
// - Buffer moves to active value at top
// - Software reaches buffer or active value per mode
// - Count write blocks matches for next tick
// - Normal mode counts up, wraps, flags overflow
// - Mode two clears counter on match A
// - Forced compare updates output in non-PWM modes, no flag
//
// The AXI4-Lite interface to the registers and the placing of the registers were decided locally.
`include "tcc_defines.svh"
module tcc_timer (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic external_count_pin,
  input wire logic [2:0] irq_ack,
  output logic [2:0] irq_req_q,
  output logic compare_out_a,
  output logic compare_out_b
);

  // ========================================================================
  // Declarations
  logic [7:0] aw_addr_q;
  logic aw_have_q;
  logic [7:0] w_data_q;
  logic w_lane0_q;
  logic w_have_q;
  logic wr_fire;
  logic wr_ok;
  logic [7:0] wr_addr;
  logic wr_ctrl_a;
  logic wr_ctrl_b;
  logic wr_count;
  logic wr_cmp_a;
  logic wr_cmp_b;
  logic wr_flag;
  logic wr_mask;
  logic [7:0] ctrl_a_q;
  logic [2:0] clock_select_q;
  logic waveform_mode_bit2_q;
  logic [2:0] waveform_mode;
  logic [7:0] count_value_q;
  logic [7:0] count_value_d;
  logic dir_up_q;
  logic dir_up_d;
  logic block_q;
  logic [2:0] timer_flag_q;
  logic [2:0] timer_flag_d;
  logic [2:0] timer_mask_q;
  logic [2:0] flag_set;
  logic ovf_set;
  logic timer_tick;
  logic [7:0] top_val;
  logic at_top;
  logic at_bottom;
  logic [7:0] compare_value_a;
  logic [7:0] compare_value_b;
  logic [7:0] buf_a;
  logic [7:0] buf_b;
  logic [7:0] rd_byte;
  logic rd_ok;
  tcc_pkg::tcc_kind_e kind;
  tcc_pkg::tcc_wave_cfg_s cfg_a;
  tcc_pkg::tcc_wave_cfg_s cfg_b;
  tcc_pkg::tcc_cnt_stat_s stat;

  // ========================================================================
  // AXI4-Lite write channel
  assign wr_fire = aw_have_q && w_have_q && !bvalid;
  assign wr_addr = aw_addr_q;
  assign wr_ok = (wr_addr == `TCC_OFS_CTRL_A) || (wr_addr == `TCC_OFS_CTRL_B)
    || (wr_addr == `TCC_OFS_COUNT) || (wr_addr == `TCC_OFS_CMP_A)
    || (wr_addr == `TCC_OFS_CMP_B) || (wr_addr == `TCC_OFS_FLAG)
    || (wr_addr == `TCC_OFS_MASK);
  assign wr_ctrl_a = wr_fire && w_lane0_q && (wr_addr == `TCC_OFS_CTRL_A);
  assign wr_ctrl_b = wr_fire && w_lane0_q && (wr_addr == `TCC_OFS_CTRL_B);
  assign wr_count = wr_fire && w_lane0_q && (wr_addr == `TCC_OFS_COUNT);
  assign wr_cmp_a = wr_fire && w_lane0_q && (wr_addr == `TCC_OFS_CMP_A);
  assign wr_cmp_b = wr_fire && w_lane0_q && (wr_addr == `TCC_OFS_CMP_B);
  assign wr_flag = wr_fire && w_lane0_q && (wr_addr == `TCC_OFS_FLAG);
  assign wr_mask = wr_fire && w_lane0_q && (wr_addr == `TCC_OFS_MASK);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      aw_have_q <= 1'b0;
      aw_addr_q <= 8'h00;
      awready <= 1'b1;
    end else if (wr_fire) begin
      aw_have_q <= 1'b0;
      awready <= 1'b0;
    end else if (awvalid && awready) begin
      aw_have_q <= 1'b1;
      aw_addr_q <= {awaddr[7:2], 2'b00};
      awready <= 1'b0;
    end else if (!aw_have_q && !bvalid) begin
      awready <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      w_have_q <= 1'b0;
      w_data_q <= 8'h00;
      w_lane0_q <= 1'b0;
      wready <= 1'b1;
    end else if (wr_fire) begin
      w_have_q <= 1'b0;
      wready <= 1'b0;
    end else if (wvalid && wready) begin
      w_have_q <= 1'b1;
      w_data_q <= wdata[7:0];
      w_lane0_q <= wstrb[0];
      wready <= 1'b0;
    end else if (!w_have_q && !bvalid) begin
      wready <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      bvalid <= 1'b0;
      bresp <= `TCC_RESP_OKAY;
    end else if (wr_fire) begin
      bvalid <= 1'b1;
      bresp <= wr_ok ? `TCC_RESP_OKAY : `TCC_RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // ========================================================================
  // AXI4-Lite read channel
  always_comb begin
    rd_ok = 1'b1;
    case ({araddr[7:2], 2'b00})
      `TCC_OFS_CTRL_A: rd_byte = ctrl_a_q;
      `TCC_OFS_CTRL_B: rd_byte = {4'h0, waveform_mode_bit2_q,
                                  clock_select_q};
      `TCC_OFS_COUNT: rd_byte = count_value_q;
      `TCC_OFS_CMP_A: rd_byte = buf_a;
      `TCC_OFS_CMP_B: rd_byte = buf_b;
      `TCC_OFS_FLAG: rd_byte = {5'h00, timer_flag_q};
      `TCC_OFS_MASK: rd_byte = {5'h00, timer_mask_q};
      default: begin
        rd_byte = 8'h00;
        rd_ok = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= `TCC_RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rdata <= {24'h00_0000, rd_byte};
      rresp <= rd_ok ? `TCC_RESP_OKAY : `TCC_RESP_SLVERR;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
      arready <= 1'b1;
    end
  end

  // ========================================================================
  // Control registers
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_a_q <= `TCC_RST_BYTE;
    end else if (wr_ctrl_a) begin
      ctrl_a_q <= w_data_q & 8'hF3;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      clock_select_q <= `TCC_CS_STOP;
      waveform_mode_bit2_q <= 1'b0;
    end else if (wr_ctrl_b) begin
      clock_select_q <= w_data_q[`TCC_CB_CS_LO +: 3];
      waveform_mode_bit2_q <= w_data_q[`TCC_CB_WGM2];
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      timer_mask_q <= 3'h0;
    end else if (wr_mask) begin
      timer_mask_q <= w_data_q[2:0];
    end
  end

  // ========================================================================
  // Mode decode
  assign waveform_mode = {waveform_mode_bit2_q,
                          ctrl_a_q[`TCC_CA_WGM_LO +: 2]};

  always_comb begin
    case (waveform_mode)
      3'h1: kind = tcc_pkg::TCC_KIND_PHASE;
      3'h2: kind = tcc_pkg::TCC_KIND_CTC;
      3'h3: kind = tcc_pkg::TCC_KIND_FAST;
      3'h5: kind = tcc_pkg::TCC_KIND_PHASE;
      3'h7: kind = tcc_pkg::TCC_KIND_FAST;
      default: kind = tcc_pkg::TCC_KIND_NORMAL;
    endcase
  end

  // Top from compare A in modes 2, 5 and 7, else the maximum
  assign top_val = (waveform_mode == 3'h2 || waveform_mode == 3'h5 ||
                    waveform_mode == 3'h7) ? compare_value_a
                                           : `TCC_MAX;
  assign at_top = (count_value_q == top_val);
  assign at_bottom = (count_value_q == `TCC_BOTTOM);

  // ========================================================================
  // Tick source
  tcc_tick_sel u_tick (
    .clk(clk),
    .reset_n(reset_n),
    .clock_select(clock_select_q),
    .ext_pin(external_count_pin),
    .tick_q(timer_tick)
  );

  // ========================================================================
  // Counter
  always_comb begin
    count_value_d = count_value_q;
    dir_up_d = dir_up_q;
    ovf_set = 1'b0;
    if (timer_tick) begin
      case (kind)
        tcc_pkg::TCC_KIND_CTC: begin
          count_value_d = at_top ? `TCC_BOTTOM
                                 : count_value_q + 8'h01;
          ovf_set = (count_value_q == `TCC_MAX);
        end
        tcc_pkg::TCC_KIND_FAST: begin
          count_value_d = at_top ? `TCC_BOTTOM : count_value_q + 8'h01;
          ovf_set = at_top;
        end
        tcc_pkg::TCC_KIND_PHASE: begin
          if (dir_up_q && at_top) begin
            dir_up_d = 1'b0;
            count_value_d = count_value_q - 8'h01;
          end else if (!dir_up_q && at_bottom) begin
            dir_up_d = 1'b1;
            count_value_d = count_value_q + 8'h01;
            ovf_set = 1'b1;
          end else begin
            count_value_d = dir_up_q ? count_value_q + 8'h01
                                     : count_value_q - 8'h01;
          end
        end
        default: begin
          count_value_d = count_value_q + 8'h01;
          ovf_set = (count_value_q == `TCC_MAX);
          dir_up_d = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      count_value_q <= `TCC_RST_BYTE;
      dir_up_q <= 1'b1;
    end else if (wr_count) begin
      count_value_q <= w_data_q;
    end else begin
      count_value_q <= count_value_d;
      dir_up_q <= dir_up_d;
    end
  end

  // Matches on the next tick after a count write are suppressed
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      block_q <= 1'b0;
    end else if (wr_count) begin
      block_q <= 1'b1;
    end else if (timer_tick) begin
      block_q <= 1'b0;
    end
  end

  // ========================================================================
  // Compare units
  assign stat = '{count: count_value_q, dir_up: dir_up_q,
                  at_top: at_top, block: block_q};
  assign cfg_a = '{kind: kind, action: ctrl_a_q[`TCC_CA_COMA_LO +: 2]};
  assign cfg_b = '{kind: kind, action: ctrl_a_q[`TCC_CA_COMB_LO +: 2]};

  tcc_cmp_unit u_cmp_a (
    .clk(clk),
    .reset_n(reset_n),
    .wr_en(wr_cmp_a),
    .wr_data(w_data_q),
    .tick(timer_tick),
    .stat(stat),
    .cfg(cfg_a),
    .force_strobe(wr_ctrl_b && w_data_q[`TCC_CB_FORCE_A]),
    .active_q(compare_value_a),
    .buffer_q(buf_a),
    .match_set(flag_set[`TCC_FLG_CMP_A]),
    .oc_q(compare_out_a)
  );

  tcc_cmp_unit u_cmp_b (
    .clk(clk),
    .reset_n(reset_n),
    .wr_en(wr_cmp_b),
    .wr_data(w_data_q),
    .tick(timer_tick),
    .stat(stat),
    .cfg(cfg_b),
    .force_strobe(wr_ctrl_b && w_data_q[`TCC_CB_FORCE_B]),
    .active_q(compare_value_b),
    .buffer_q(buf_b),
    .match_set(flag_set[`TCC_FLG_CMP_B]),
    .oc_q(compare_out_b)
  );

  assign flag_set[`TCC_FLG_OVF] = ovf_set;

  // ========================================================================
  // Flags and interrupt requests
  // A set in the cycle of a clear wins
  always_comb begin
    timer_flag_d = timer_flag_q;
    if (wr_flag) begin
      timer_flag_d = timer_flag_d & ~w_data_q[2:0];
    end
    timer_flag_d = (timer_flag_d & ~irq_ack) | flag_set;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      timer_flag_q <= 3'h0;
    end else begin
      timer_flag_q <= timer_flag_d;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_req_q <= 3'h0;
    end else begin
      irq_req_q <= timer_flag_d & timer_mask_q;
    end
  end

endmodule // tcc_timer

// ### testbench/tcc_timer_props.sv
// Register bus timing checks for the timer, bound to its top module.
// Assumes one clock domain and the asynchronous active-low reset.
module tcc_timer_props (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  input wire logic rready
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================================
  // Assertions
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  sequence s_wr_both;
    awvalid && awready && wvalid && wready;
  endsequence
  sequence s_rd_take;
    arvalid && arready;
  endsequence
  chk_wr_answer:
    assert property (s_wr_both |-> ##[1:2] bvalid)
    else $error("write response missing");
  chk_rd_answer:
    assert property (s_rd_take |=> rvalid)
    else $error("read data missing");
  chk_b_held:
    assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped");
  chk_r_held:
    assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped");
  chk_ar_busy:
    assert property (rvalid |-> !arready)
    else $error("read address open during read");
  chk_aw_busy:
    assert property (bvalid |-> !awready && !wready)
    else $error("write channels open during response");
  chk_rdata_top:
    assert property (rvalid |-> rdata[31:8] == 24'h000000)
    else $error("read data above byte");
  chk_err_zero:
    assert property (rvalid && rresp != 2'h0 |-> rdata == 32'h00000000)
    else $error("error read carries data");
endmodule // tcc_timer_props

bind tcc_timer tcc_timer_props i_tcc_timer_props (.clk(clk),
  .reset_n(reset_n), .awvalid(awvalid), .awready(awready),
  .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
  .bready(bready), .arvalid(arvalid), .arready(arready), .rdata(rdata),
  .rresp(rresp), .rvalid(rvalid), .rready(rready));

// ### testbench/tcc_ext_src.sv
// External event source: bursts of pulses on the count pin.
// Assumes half is at least 3 so the pin synchroniser sees every level.
module tcc_ext_src (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic go,
  input wire logic [7:0] num,
  input wire logic [3:0] half,
  output logic pin_q,
  output logic busy_q
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] left_q;
  logic [4:0] ph_q;
  // ==========================================================================
  // Pulse train, pin idles low between bursts
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      left_q <= 8'h00;
      ph_q <= 5'h00;
      pin_q <= 1'b0;
      busy_q <= 1'b0;
    end else if (go && !busy_q) begin
      left_q <= num;
      ph_q <= 5'h00;
      busy_q <= 1'b1;
    end else if (busy_q) begin
      ph_q <= ph_q + 5'h01;
      if (ph_q == {1'b0, half}) pin_q <= 1'b1;
      if (ph_q == {half, 1'b0}) begin
        pin_q <= 1'b0;
        ph_q <= 5'h00;
        left_q <= left_q - 8'h01;
        busy_q <= (left_q != 8'h01);
      end
    end
  end
endmodule // tcc_ext_src

// ### testbench/tb.sv
// Self-checking bench for the timer over its register bus.
// Assumes tcc_timer with the checker bound and tcc_ext_src on the pin.
`include "tcc_defines.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, reset_n, awvalid, wvalid, bready, arvalid, rready, bvalid;
  logic rvalid, awready, wready, arready, go, busy, pin, out_a, out_b, ex;
  logic [7:0] awaddr, araddr, num, v, n, rv;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp;
  logic [2:0] irq_ack, irq_req;
  logic [3:0] half;
  logic [1:0] acts [5] = '{2'h1, 2'h3, 2'h1, 2'h2, 2'h1};
  int error_cnt, num_checks;
  tcc_timer i_tcc_timer (.clk(clk), .reset_n(reset_n), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hF),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .external_count_pin(pin), .irq_ack(irq_ack),
    .irq_req_q(irq_req), .compare_out_a(out_a), .compare_out_b(out_b));
  tcc_ext_src i_tcc_ext_src (.clk(clk), .reset_n(reset_n), .go(go),
    .num(num), .half(half), .pin_q(pin), .busy_q(busy));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // ==========================================================================
  // Bus tasks and checks
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] s);
    num_checks++;
    if (s !== e) begin
      $display("[ERR] %s expected %h seen %h", nm, e, s);
      error_cnt++;
    end
  endtask
  function automatic logic [1:0] resp_of(input logic [7:0] a);
    return (a > `TCC_OFS_MASK) ? `TCC_RESP_SLVERR : `TCC_RESP_OKAY;
  endfunction
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic pa, pw;
    pa = 1'b1;
    pw = 1'b1;
    @(posedge clk);
    awaddr <= a;
    wdata <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (pa || pw) begin
      @(posedge clk);
      if (pa && awready) awvalid <= 1'b0;
      if (pw && wready) wvalid <= 1'b0;
      pa = pa && !awready;
      pw = pw && !wready;
    end
    do @(posedge clk); while (bvalid !== 1'b1);
    bready <= 1'b1;
    @(posedge clk);
    bready <= 1'b0;
    chk("bresp", 32'(resp_of(a)), 32'(bresp));
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk); while (rvalid !== 1'b1);
    rready <= 1'b1;
    @(posedge clk);
    rready <= 1'b0;
    d = rdata[7:0];
    chk("rresp", 32'(resp_of(a)), 32'(rresp));
  endtask
  task automatic rchk(input string nm, input logic [7:0] a,
                      input logic [7:0] e);
    rd(a, rv);
    chk(nm, 32'(e), 32'(rv));
  endtask
  task automatic run(input int c);
    wr(`TCC_OFS_CTRL_B, 8'h01);
    repeat (c) @(posedge clk);
    wr(`TCC_OFS_CTRL_B, 8'h00);
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // ==========================================================================
  // Tests
  initial begin
    reset_n = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready, go} = 6'h00;
    {awaddr, araddr, num, wdata, irq_ack, half, ex} = '0;
    void'($urandom(30015));
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    for (int a = 0; a <= 8'h1C; a += 4) rchk("reset", 8'(a), 8'h00);
    wr(8'h1C, 8'h5A);
    $display("test reset done");
    foreach (acts[i]) begin
      wr(`TCC_OFS_CTRL_A, {acts[i], acts[i], 4'h0});
      wr(`TCC_OFS_CTRL_B, 8'hC0);
      repeat (2) @(posedge clk);
      ex = (acts[i] == 2'h1) ? !ex : (acts[i] == 2'h3);
      chk("out_a", 32'(ex), 32'(out_a));
      chk("out_b", 32'(ex), 32'(out_b));
    end
    wr(`TCC_OFS_CTRL_A, 8'h00);
    rchk("flag_force", `TCC_OFS_FLAG, 8'h00);
    $display("test force done");
    v = 8'($urandom);
    wr(`TCC_OFS_COUNT, v);
    repeat (30) @(posedge clk);
    rchk("stopped", `TCC_OFS_COUNT, v);
    $display("test stop done");
    n = 8'($urandom_range(1, 16));
    wr(`TCC_OFS_MASK, 8'h07);
    wr(`TCC_OFS_CMP_A, n);
    wr(`TCC_OFS_CMP_B, 8'hF8);
    wr(`TCC_OFS_COUNT, 8'hF0);
    run(40);
    rchk("flag_all", `TCC_OFS_FLAG, 8'h07);
    chk("irq_all", 32'h7, 32'(irq_req));
    @(posedge clk);
    irq_ack <= 3'h1;
    @(posedge clk);
    irq_ack <= 3'h0;
    repeat (3) @(posedge clk);
    rchk("flag_ack", `TCC_OFS_FLAG, 8'h06);
    wr(`TCC_OFS_FLAG, 8'h00);
    rchk("flag_keep", `TCC_OFS_FLAG, 8'h06);
    wr(`TCC_OFS_FLAG, 8'h06);
    rchk("flag_clr", `TCC_OFS_FLAG, 8'h00);
    chk("irq_none", 32'h0, 32'(irq_req));
    $display("test normal done");
    wr(`TCC_OFS_CMP_A, 8'h40);
    wr(`TCC_OFS_COUNT, 8'h40);
    run(2);
    rchk("blocked", `TCC_OFS_FLAG, 8'h00);
    $display("test block done");
    n = 8'($urandom_range(3, 20));
    wr(`TCC_OFS_CTRL_A, 8'h02);
    wr(`TCC_OFS_CMP_A, n);
    wr(`TCC_OFS_COUNT, 8'h00);
    run(60);
    rd(`TCC_OFS_COUNT, rv);
    chk("ctc_top", 32'h1, 32'(rv <= n));
    rchk("ctc_flag", `TCC_OFS_FLAG, 8'h02);
    wr(`TCC_OFS_CTRL_A, 8'h00);
    $display("test ctc done");
    for (int e = 0; e < 2; e++) begin
      wr(`TCC_OFS_COUNT, 8'h00);
      wr(`TCC_OFS_CTRL_B, (e == 0) ? 8'h07 : 8'h06);
      @(posedge clk);
      num <= 8'($urandom_range(3, 12));
      half <= 4'($urandom_range(3, 9));
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      do @(posedge clk); while (busy);
      repeat (8) @(posedge clk);
      wr(`TCC_OFS_CTRL_B, 8'h00);
      rchk("ext_edges", `TCC_OFS_COUNT, num);
    end
    $display("test ext done");
    wr(`TCC_OFS_FLAG, 8'h07);
    wr(`TCC_OFS_CTRL_A, 8'h03);
    wr(`TCC_OFS_CMP_A, 8'h21);
    wr(`TCC_OFS_COUNT, 8'h20);
    run(2);
    rchk("buffered", `TCC_OFS_FLAG, 8'h00);
    rchk("cmp_buf", `TCC_OFS_CMP_A, 8'h21);
    $display("test buffer done");
    final_report();
  end
  initial begin
    repeat (30000) @(posedge clk);
    error_cnt++;
    $display("[ERR] watchdog expected end seen hang");
    final_report();
  end
endmodule // tb
